// *** verilog/flash_erase_pkg.sv ***
// constants of the erase and suspend sequencer
package flash_erase_pkg;
  localparam int CLK_MHZ = 100;
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK32_ERASE_A4 = 8'h5c;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_BLOCK64_ERASE_A4 = 8'hdc;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_ENTER_4BYTE = 8'hb7;
  localparam logic [7:0] OP_EXIT_4BYTE = 8'he9;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
  // frame lengths in bits
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR3 = 6'h20;
  localparam logic [5:0] BITS_ADDR4 = 6'h28;
  localparam logic [5:0] BITS_MAX = 6'h3f;
  // status word bit positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_ERASE_SUS = 10;
  localparam int ST_PROG_SUS = 15;
  localparam int ST_FOUR_BYTE = 16;
  localparam int ST_QUAD = 17;
  // array geometry
  localparam int BIG_BLOCK_LSB = 16;
  localparam int BIG_BLOCK_MSB = 24;
  // register map, byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h04;
  localparam logic [7:0] REG_SUSPEND_BLOCK = 8'h08;
  localparam logic [4:0] CONFIG_RESET = 5'h00;
  // timing
  localparam int ERASE_SUSPEND_LATENCY_US = 20;
  localparam int ERASE_SUSPEND_LATENCY_CYC = ERASE_SUSPEND_LATENCY_US * CLK_MHZ;
  localparam logic [31:0] LATENCY_LOAD = ERASE_SUSPEND_LATENCY_CYC[31:0];
endpackage

// *** verilog/flash_erase_suspend_sequencer.sv ***
// serial flash erase and suspend command sequencer with wishbone status port
//
// Function
// R1: opcode 52h erases the 32KB block holding the address, after write enable.
// R2: select must rise right after the last address bit, else erase discarded.
// R3: select rise starts timed block erase; write_in_progress high until done.
// R4: write enable latch is cleared during a block erase.
// R5: no block erase on a block covered by block_protect_bits.
// R6: opcode 5Ch always carries a four-byte address.
// R7: opcode D8h erases a 64KB block with the same checks and timing.
// R8: opcode DCh always carries a four-byte address.
// R9: opcodes C7h and 60h both start chip erase to all FFh.
// R10: chip erase needs write enable latch set.
// R11: select must rise right after the eighth opcode bit for chip erase.
// R12: chip erase runs chip_erase_time with write_in_progress high, status readable.
// R13: chip erase completion clears write enable latch, device ready again.
// R14: chip erase only when all block_protect_bits are zero.
// R15: opcode 75h suspends a running program, sector or block erase.
// R16: host waits program_to_suspend_delay or erase_to_suspend_delay before suspend.
// R17: during program suspend, everything but the suspended page is accessible.
// R18: during erase suspend, everything but the suspended big block is accessible; here no erase starts while suspended.
// R19: a status register write is never suspended.
// R20: suspend latency passes before latch clears and suspend flag sets.
// R21: status read and reset opcodes are taken at any time after suspend.
// R22: program suspend in status bit 15, erase suspend in bit 10.
// R23: suspend flag clears on resume.
// R24: while busy and not suspended only status read, suspend, reset taken.
module flash_erase_suspend_sequencer #(
  parameter int BLOCK_ERASE_TIME_US = 1000,
  parameter int CHIP_ERASE_TIME_US = 100000
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * flash_erase_pkg::CLK_MHZ;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * flash_erase_pkg::CLK_MHZ;
  localparam logic [31:0] BLOCK_LOAD = BLOCK_ERASE_CYC[31:0];
  localparam logic [31:0] CHIP_LOAD = CHIP_ERASE_CYC[31:0];

  typedef enum logic [1:0] {ST_IDLE, ST_ERASING, ST_SUSP_WAIT, ST_SUSPENDED} seq_state_t;

  seq_state_t state_q;
  logic [2:0] sclk_sync_q;
  logic [2:0] cs_sync_q;
  logic [3:0] io_meta_q;
  logic [3:0] io_s_q;
  logic [31:0] sh_q;
  logic [5:0] bits_q;
  logic [7:0] op_q;
  logic rd_on_q;
  logic rd_hi_q;
  logic [2:0] obit_q;
  logic [7:0] out_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;
  logic wel_q;
  logic erase_sus_q;
  logic four_byte_q;
  logic quad_q;
  logic rst_en_q;
  logic chip_q;
  logic [31:0] erase_cnt_q;
  logic [31:0] lat_cnt_q;
  logic [8:0] tgt_blk_q;
  logic [8:0] susp_blk_q;
  logic [4:0] bp_q;
  logic [31:0] wb_dat_q;
  logic wb_ack_q;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_low;
  logic write_in_progress;
  logic [15:0] stat16;
  logic [31:0] sh_d;
  logic [5:0] step;
  logic [5:0] bits_d;
  logic blk_cmd;
  logic blk_a4;
  logic blk_len_ok;
  logic [8:0] cmd_blk;
  logic blk_ok;
  logic chip_cmd;
  logic chip_ok;

  // block_protect_bits select the top 2^(bp-1) big blocks; ten and up cover all
  function automatic logic blk_protected(input logic [4:0] bp, input logic [8:0] blk);
    logic [9:0] limit;
    limit = 10'h200 - (10'h001 << (bp - 5'h01));
    if (bp == 5'h00) begin
      return 1'b0;
    end
    if (bp >= 5'h0a) begin
      return 1'b1;
    end
    return {1'b0, blk} >= limit;
  endfunction

  // two flip-flops before any logic; third stage only for edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sclk_sync_q <= 3'h0;
      cs_sync_q <= 3'h7;
      io_meta_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
      cs_sync_q <= {cs_sync_q[1:0], spi_cs_n};
      io_meta_q <= io_in;
      io_s_q <= io_meta_q;
    end
  end

  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
  assign cs_low = ~cs_sync_q[1];

  assign write_in_progress = (state_q == ST_ERASING) || (state_q == ST_SUSP_WAIT); // see R3 see R12
  always_comb begin
    stat16 = 16'h0000;
    stat16[flash_erase_pkg::ST_WIP] = write_in_progress;
    stat16[flash_erase_pkg::ST_WEL] = wel_q;
    stat16[flash_erase_pkg::ST_BP_LSB +: 5] = bp_q;
    stat16[flash_erase_pkg::ST_ERASE_SUS] = erase_sus_q; // see R22
    stat16[flash_erase_pkg::ST_PROG_SUS] = 1'b0; // no program engine here, see R22 see R17
  end

  assign step = quad_q ? 6'h04 : 6'h01;
  assign sh_d = quad_q ? {sh_q[27:0], io_s_q} : {sh_q[30:0], io_s_q[0]};
  assign bits_d = (bits_q > (flash_erase_pkg::BITS_MAX - step)) ? flash_erase_pkg::BITS_MAX : bits_q + step;

  // serial input: opcode and address bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_q <= 32'h0000_0000;
      bits_q <= 6'h00;
      op_q <= 8'h00;
    end else if (!cs_low) begin
      bits_q <= 6'h00;
    end else if (sclk_rise) begin
      sh_q <= sh_d;
      bits_q <= bits_d;
      if (bits_d == flash_erase_pkg::BITS_OPCODE) begin
        op_q <= sh_d[7:0];
      end
    end
  end

  // serial output of the status byte, repeated while select stays low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_on_q <= 1'b0;
      rd_hi_q <= 1'b0;
      obit_q <= 3'h0;
      out_q <= 8'h00;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else if (!cs_low) begin
      rd_on_q <= 1'b0;
      io_oe_q <= 4'h0;
      io_out_q <= 4'h0;
    end else if (sclk_rise && bits_d == flash_erase_pkg::BITS_OPCODE && bits_q != bits_d) begin
      rd_on_q <= (sh_d[7:0] == flash_erase_pkg::OP_READ_STATUS_LO) || // see R21
                 (sh_d[7:0] == flash_erase_pkg::OP_READ_STATUS_HI);
      rd_hi_q <= sh_d[7:0] == flash_erase_pkg::OP_READ_STATUS_HI;
      obit_q <= 3'h0;
    end else if (sclk_fall && rd_on_q) begin
      if (quad_q) begin
        io_out_q <= (obit_q == 3'h0) ? (rd_hi_q ? stat16[15:12] : stat16[7:4]) : out_q[7:4];
        out_q <= (obit_q == 3'h0) ? {(rd_hi_q ? stat16[11:8] : stat16[3:0]), 4'h0} : {out_q[3:0], 4'h0};
        io_oe_q <= 4'hf;
        obit_q <= obit_q + 3'h4;
      end else begin
        io_out_q <= {2'h0, ((obit_q == 3'h0) ? (rd_hi_q ? stat16[15] : stat16[7]) : out_q[7]), 1'b0};
        out_q <= (obit_q == 3'h0) ? {(rd_hi_q ? stat16[14:8] : stat16[6:0]), 1'b0} : {out_q[6:0], 1'b0};
        io_oe_q <= 4'h2;
        obit_q <= obit_q + 3'h1;
      end
    end
  end

  // command checks at the rise of select
  assign blk_a4 = (op_q == flash_erase_pkg::OP_BLOCK32_ERASE_A4) || // see R6
                  (op_q == flash_erase_pkg::OP_BLOCK64_ERASE_A4); // see R8
  assign blk_cmd = blk_a4 || (op_q == flash_erase_pkg::OP_BLOCK32_ERASE) || // see R1
                   (op_q == flash_erase_pkg::OP_BLOCK64_ERASE); // see R7
  // select must rise exactly on the last address bit
  assign blk_len_ok = (blk_a4 || four_byte_q) ? (bits_q == flash_erase_pkg::BITS_ADDR4) :
                      (bits_q == flash_erase_pkg::BITS_ADDR3); // see R2
  assign cmd_blk = (blk_a4 || four_byte_q) ?
                   sh_q[flash_erase_pkg::BIG_BLOCK_MSB:flash_erase_pkg::BIG_BLOCK_LSB] :
                   {1'b0, sh_q[23:flash_erase_pkg::BIG_BLOCK_LSB]};
  assign blk_ok = blk_cmd && blk_len_ok && wel_q && !blk_protected(bp_q, cmd_blk); // see R5
  assign chip_cmd = (op_q == flash_erase_pkg::OP_CHIP_ERASE_A) || // see R9
                    (op_q == flash_erase_pkg::OP_CHIP_ERASE_B);
  assign chip_ok = chip_cmd && bits_q == flash_erase_pkg::BITS_OPCODE && // see R11
                   wel_q && // see R10
                   bp_q == 5'h00; // see R14

  // erase sequencer, latches and modes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      wel_q <= 1'b0;
      erase_sus_q <= 1'b0;
      four_byte_q <= 1'b0;
      quad_q <= 1'b0;
      rst_en_q <= 1'b0;
      chip_q <= 1'b0;
      erase_cnt_q <= 32'h0000_0000;
      lat_cnt_q <= 32'h0000_0000;
      tgt_blk_q <= 9'h000;
      susp_blk_q <= 9'h000;
    end else begin
      unique case (state_q)
        ST_ERASING: begin
          if (erase_cnt_q <= 32'h0000_0001) begin
            state_q <= ST_IDLE;
            wel_q <= 1'b0; // see R13
          end else begin
            erase_cnt_q <= erase_cnt_q - 32'h0000_0001;
          end
        end
        ST_SUSP_WAIT: begin
          if (lat_cnt_q <= 32'h0000_0001) begin
            state_q <= ST_SUSPENDED;
            wel_q <= 1'b0; // see R20
            erase_sus_q <= 1'b1; // see R22
            susp_blk_q <= tgt_blk_q; // see R18
          end else begin
            lat_cnt_q <= lat_cnt_q - 32'h0000_0001;
          end
        end
        ST_IDLE, ST_SUSPENDED: begin
        end
      endcase
      if (cs_rise && bits_q == flash_erase_pkg::BITS_OPCODE) begin
        rst_en_q <= op_q == flash_erase_pkg::OP_RESET_ENABLE; // see R21
        if (op_q == flash_erase_pkg::OP_RESET && rst_en_q) begin
          state_q <= ST_IDLE; // see R21
          wel_q <= 1'b0;
          erase_sus_q <= 1'b0;
          four_byte_q <= 1'b0;
          quad_q <= 1'b0;
        end else if (state_q == ST_IDLE || state_q == ST_SUSPENDED) begin
          unique case (op_q)
            flash_erase_pkg::OP_WRITE_ENABLE: wel_q <= 1'b1;
            flash_erase_pkg::OP_WRITE_DISABLE: wel_q <= 1'b0;
            flash_erase_pkg::OP_ENTER_4BYTE: four_byte_q <= 1'b1;
            flash_erase_pkg::OP_EXIT_4BYTE: four_byte_q <= 1'b0;
            flash_erase_pkg::OP_ENTER_QUAD: quad_q <= 1'b1;
            flash_erase_pkg::OP_EXIT_QUAD: quad_q <= 1'b0;
            flash_erase_pkg::OP_RESUME: begin
              if (state_q == ST_SUSPENDED) begin
                state_q <= ST_ERASING;
                erase_sus_q <= 1'b0; // see R23
              end
            end
            default: begin
              if (chip_ok && state_q == ST_IDLE) begin
                state_q <= ST_ERASING; // see R12
                chip_q <= 1'b1;
                erase_cnt_q <= CHIP_LOAD;
              end
            end
          endcase
        end else if (state_q == ST_ERASING && op_q == flash_erase_pkg::OP_SUSPEND && !chip_q) begin
          state_q <= ST_SUSP_WAIT; // only block erases suspend, see R15 see R24 see R19
          lat_cnt_q <= flash_erase_pkg::LATENCY_LOAD; // see R20
        end
      end else if (cs_rise && blk_ok && state_q == ST_IDLE) begin
        // erases are refused while busy or suspended
        state_q <= ST_ERASING; // see R3 see R24 see R18
        chip_q <= 1'b0;
        erase_cnt_q <= BLOCK_LOAD;
        tgt_blk_q <= cmd_blk;
        wel_q <= 1'b0; // see R4
        rst_en_q <= 1'b0;
      end else if (cs_rise && bits_q != 6'h00) begin
        rst_en_q <= 1'b0;
      end
    end
  end

  // wishbone config register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bp_q <= flash_erase_pkg::CONFIG_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_q && wb_sel_i[0] &&
                 wb_adr_i == flash_erase_pkg::REG_CONFIG) begin
      bp_q <= wb_dat_i[4:0];
    end
  end

  // wishbone answer, one wait cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      wb_dat_q <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_q && !wb_we_i) begin
        unique case (wb_adr_i)
          flash_erase_pkg::REG_STATUS:
            wb_dat_q <= {14'h0000, quad_q, four_byte_q, stat16};
          flash_erase_pkg::REG_CONFIG: wb_dat_q <= {27'h000_0000, bp_q};
          flash_erase_pkg::REG_SUSPEND_BLOCK: wb_dat_q <= {23'h00_0000, susp_blk_q};
          default: wb_dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;
endmodule

// *** sim/spi_host_model.sv ***
// host side serial flash controller model, single or quad line mode
module spi_host_model (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    io_in = 4'h5;
  end
  // n bits msb first; reply bits after the opcode
  // frame starts just after a system clock edge, so no pin moves on a sampling edge
  task automatic frame(input logic [39:0] d, input int n, input logic q, output logic [7:0] rd);
    int w;
    w = q ? 4 : 1;
    rd = 8'h00;
    @(posedge clk_sys);
    #1 spi_cs_n = 1'b0;
    for (int i = n - w; i >= 0; i -= w) begin
      io_in = q ? d[i +: 4] : {4{d[i]}};
      #62.5 spi_sclk = 1'b1;
      if (n - i > 8) rd = q ? {rd[3:0], io_out} : {rd[6:0], io_out[1]};
      #62.5 spi_sclk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    io_in = ~io_in;
    #250;
  endtask
endmodule

// *** sim/flash_erase_suspend_sequencer_props.sv ***
// port checks of the erase and suspend sequencer
module flash_erase_suspend_sequencer_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic [3:0] io_oe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire st_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h00;
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("stray ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  a_oe_release: assert property (spi_cs_n [*5] |-> io_oe == 4'h0) else $error("pins driven while idle");
  a_oe_shape: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf) else $error("odd enables");
  a_sus_idle: assert property (st_rd && wb_dat_o[10] |-> !wb_dat_o[0]) else $error("busy while suspended");
  a_prog_sus_zero: assert property (st_rd |-> !wb_dat_o[15]) else $error("program suspend set");
  cover property (st_rd && wb_dat_o[0]);
  cover property (st_rd && wb_dat_o[10]);
  cover property (io_oe == 4'h2);
  cover property (io_oe == 4'hf);
endmodule
bind flash_erase_suspend_sequencer flash_erase_suspend_sequencer_props chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .io_oe(io_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// *** sim/flash_erase_suspend_sequencer_bench.sv ***
// self-checking bench of the erase and suspend sequencer
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("Error at %0t: %h not %h", $time, g, e); end end
module flash_erase_suspend_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BE_US = 30;
  localparam int CE_US = 5;
  logic clk_sys, sys_rst, spi_sclk, spi_cs_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] io_in, io_out, io_oe, wb_sel_i;
  logic [7:0] wb_adr_i, rd;
  logic [31:0] wb_dat_i, wb_dat_o, d;
  logic [7:0] ops [4] = '{8'h52, 8'hd8, 8'h5c, 8'hdc};
  int errors = 0;
  int checks_done = 0;
  logic qd = 1'b0;
  flash_erase_suspend_sequencer #(.BLOCK_ERASE_TIME_US(BE_US), .CHIP_ERASE_TIME_US(CE_US)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  spi_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .io_in(io_in),
    .io_out(io_out));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // status as {erase suspended, write enable latch, write in progress}
  task automatic st(input logic [2:0] e);
    wb(1'b0, 8'h00, 32'h0);
    `CHK({d[10], d[1], d[0]}, e)
  endtask
  task automatic cmd(input logic [39:0] v, input int n);
    host.frame(v, n, qd, rd);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #600us;
    errors++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wb_sel_i <= 4'hf;
    wb(1'b0, 8'h04, 32'h0);
    `CHK(d, 32'h0)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(d, 32'h0)
    st(3'b000);
    cmd(40'hc7, 8);
    st(3'b000);
    cmd(40'h06, 8);
    wb(1'b1, 8'h04, 32'h1);
    cmd(40'h60, 8);
    st(3'b010);
    wb(1'b1, 8'h04, 32'h0);
    cmd(40'hc700, 16);
    st(3'b010);
    for (int k = 0; k < 2; k++) begin
      cmd(40'h06, 8);
      cmd(k ? 40'h60 : 40'hc7, 8);
      st(3'b011);
      cmd(40'h0500, 16);
      `CHK(rd[0], 1'b1)
      repeat (CE_US * 100) @(posedge clk_sys);
      st(3'b000);
    end
    for (int k = 0; k < 4; k++) begin
      cmd(40'h06, 8);
      cmd(k < 2 ? {ops[k], 24'h058000} : {ops[k], 32'h00058000}, k < 2 ? 32 : 40);
      st(3'b001);
      cmd(40'h06, 8);
      st(3'b001);
      repeat (BE_US * 100) @(posedge clk_sys);
      st(3'b000);
    end
    cmd(40'h06, 8);
    cmd({8'h52, 32'h0}, 40);
    st(3'b010);
    wb(1'b1, 8'h04, 32'h1);
    cmd({8'hdc, 32'h01ff0000}, 40);
    st(3'b010);
    wb(1'b1, 8'h04, 32'h0);
    cmd({8'hd8, 24'h030000}, 32);
    repeat (100) @(posedge clk_sys);
    cmd(40'h75, 8);
    cmd(40'h0500, 16);
    `CHK(rd[0], 1'b1)
    repeat (2000) @(posedge clk_sys);
    st(3'b100);
    cmd(40'h3500, 16);
    `CHK(rd[2], 1'b1)
    wb(1'b0, 8'h08, 32'h0);
    `CHK(d, 32'h3)
    cmd(40'h06, 8);
    cmd({8'hd8, 24'h050000}, 32);
    cmd(40'h04, 8);
    st(3'b100);
    cmd(40'h7a, 8);
    st(3'b001);
    repeat (BE_US * 100) @(posedge clk_sys);
    st(3'b000);
    cmd(40'hb7, 8);
    cmd(40'h06, 8);
    cmd({8'h52, 24'h058000}, 32);
    st(3'b010);
    cmd({8'h52, 32'h00058000}, 40);
    st(3'b001);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(d[17:16], 2'b01)
    cmd(40'h66, 8);
    cmd(40'h99, 8);
    wb(1'b0, 8'h00, 32'h0);
    `CHK({d[17:16], d[10], d[1], d[0]}, 5'h00)
    cmd(40'h38, 8);
    qd = 1'b1;
    cmd(40'h06, 8);
    cmd(40'hc7, 8);
    cmd(40'h0500, 16);
    `CHK(rd[1:0], 2'b11)
    repeat (CE_US * 100) @(posedge clk_sys);
    cmd(40'h0500, 16);
    `CHK(rd[1:0], 2'b00)
    cmd(40'hff, 8);
    qd = 1'b0;
    st(3'b000);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(d[17:16], 2'b00)
    finish_test();
  end
endmodule
